// file: include/mgi_pkg.sv
// package: constants shared by both ends of the magnetometer link
package mgi_pkg;
  // ==========================================================
  // link timing
  localparam int CLK_HZ = 100000000;
  localparam int BUS_STD_HZ = 100000;
  localparam int BUS_FAST_HZ = 400000;
  localparam int HALF_STD = CLK_HZ / (2 * BUS_STD_HZ);
  localparam int HALF_FAST = CLK_HZ / (2 * BUS_FAST_HZ);
  localparam logic [9:0] HALF_STD_CNT = HALF_STD[9:0];
  localparam logic [9:0] HALF_FAST_CNT = HALF_FAST[9:0];
  localparam logic [9:0] CNT_ZERO = 10'h000;
  localparam logic [9:0] CNT_ONE = 10'h001;
  // ==========================================================
  // addressing
  localparam logic [6:0] SLAVE_ADDR_FIELD = 7'h1E;
  localparam logic [7:0] ADDR_WR_BYTE = 8'h3C;
  localparam logic [7:0] ADDR_RD_BYTE = 8'h3D;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_ONE = 4'h1;
  // ==========================================================
  // register map
  localparam logic [7:0] REG_CONFIG_A = 8'h00;
  localparam logic [7:0] REG_CONFIG_B = 8'h01;
  localparam logic [7:0] REG_OP_MODE = 8'h02;
  localparam logic [7:0] REG_X_HIGH = 8'h03;
  localparam logic [7:0] REG_X_LOW = 8'h04;
  localparam logic [7:0] REG_Y_HIGH = 8'h05;
  localparam logic [7:0] REG_Y_LOW = 8'h06;
  localparam logic [7:0] REG_Z_HIGH = 8'h07;
  localparam logic [7:0] REG_Z_LOW = 8'h08;
  localparam logic [7:0] REG_STATE_FLAGS = 8'h09;
  localparam logic [7:0] REG_IDENT_FIRST = 8'h0A;
  localparam logic [7:0] REG_IDENT_SECOND = 8'h0B;
  localparam logic [7:0] REG_IDENT_THIRD = 8'h0C;
  localparam logic [7:0] PTR_WRAP_TO_ZERO = 8'h0C;
  localparam logic [7:0] PTR_ZERO = 8'h00;
  localparam logic [7:0] PTR_ONE = 8'h01;
  localparam logic [7:0] CONFIG_A_RESET = 8'h10;
  localparam logic [7:0] CONFIG_B_RESET = 8'h20;
  localparam logic [7:0] OP_MODE_RESET = 8'h03;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // defined bits of each writable register
  localparam logic [7:0] CONFIG_A_MASK = 8'h1F;
  localparam logic [7:0] CONFIG_B_MASK = 8'hE0;
  localparam logic [7:0] OP_MODE_MASK = 8'h03;
  // ==========================================================
  // master command codes
  localparam logic [1:0] CMD_WRITE = 2'h0;
  localparam logic [1:0] CMD_READ = 2'h1;
  localparam logic [1:0] CMD_STOP = 2'h2;
  localparam logic [1:0] CMD_START = 2'h3;
endpackage

// file: include/mgi_link_if.sv
// interface: the two-wire link between the master end and the device end
`timescale 1ns/1ps
`default_nettype none
interface mgi_link_if;
  logic scl_out;
  logic scl_oe_n;
  logic sda_m_out;
  logic sda_m_oe_n;
  logic sda_d_out;
  logic sda_d_oe_n;
  logic scl_d_oe_n;
  // open-drain wired levels, pulled high when nobody pulls low
  wire scl = !((!scl_oe_n && !scl_out) || !scl_d_oe_n);
  wire sda = !((!sda_m_oe_n && !sda_m_out) || (!sda_d_oe_n && !sda_d_out));
  modport master (output scl_out, output scl_oe_n, output sda_m_out,
    output sda_m_oe_n, input scl, input sda);
  modport device (output sda_d_out, output sda_d_oe_n, output scl_d_oe_n,
    input scl, input sda);
endinterface
`default_nettype wire

// file: logic/mgi_ptr_step.sv
// module: next register pointer after a data byte
`timescale 1ns/1ps
`default_nettype none
module mgi_ptr_step
  import mgi_pkg::*;
(
  input wire logic [7:0] ptr,
  output logic [7:0] ptr_next
);
  // wrap points keep burst reads cycling over the sample registers
  always_comb begin
    if (ptr == REG_STATE_FLAGS) begin
      ptr_next = REG_X_HIGH;
    end else if (ptr >= PTR_WRAP_TO_ZERO) begin
      ptr_next = PTR_ZERO;
    end else begin
      ptr_next = ptr + PTR_ONE;
    end
  end
endmodule
`default_nettype wire

// file: logic/mgi_dev.sv
// module: device end, bus slave and magnetometer register file
// Operation
// - slave on two-wire bus, 100/400 kbps
// - answer only to address 0011110
// - first byte: address plus direction bit
// - ninth clock: receiver pulls low to acknowledge
// - data changes only while clock low
// - repeated start decodes a new address
// - start, address, data bytes, then stop
// - first written byte loads register pointer
// - pointer advances after every data byte
// - 09 goes to 03, 12+ to 00
// - pointer itself is never readable
// - undefined locations read as zero
// - undefined locations and bits ignore writes
// - binary or ascii in, binary out
// - master never writes reserved locations
// - calibration registers restored at power-up
// - slave may hold clock low to stall
//
// Chosen here: parallel ports for samples, flags and config registers.
`timescale 1ns/1ps
`default_nettype none
module mgi_dev
  import mgi_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  mgi_link_if.device link,
  input wire logic [47:0] sample_data,
  input wire logic [7:0] state_flags,
  input wire logic stall_req,
  output logic [7:0] config_a,
  output logic [7:0] config_b,
  output logic [7:0] op_mode,
  output logic busy
);
  import mgi_pkg::*;

  // arbitrary identity values, not taken from any part
  localparam logic [7:0] IDENT_FIRST = 8'hA1;
  localparam logic [7:0] IDENT_SECOND = 8'hB2;
  localparam logic [7:0] IDENT_THIRD = 8'hC3;
  // the clock fall that ends a start wraps this to bit zero
  localparam logic [3:0] BIT_PRE = 4'hF;

  // ==========================================================
  // state
  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_ADDR = 3'b001,
    D_PTR = 3'b011,
    D_WDATA = 3'b010,
    D_RDATA = 3'b110,
    D_IGNORE = 3'b111
  } mgi_dstate_type;

  typedef struct packed {
    mgi_dstate_type st;
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic ack_drive;
    logic tx_on;
    logic sda_low;
    logic master_nack;
    logic [7:0] cfg_a;
    logic [7:0] cfg_b;
    logic [7:0] mode;
  } mgi_dev_type;

  mgi_dev_type cur_ff;
  mgi_dev_type nxt_cur;
  logic [7:0] ptr_adv;
  logic [7:0] rd_byte;
  logic start_seen;
  logic stop_seen;
  logic scl_rise;
  logic scl_fall;

  mgi_ptr_step u_step (
    .ptr(cur_ff.ptr),
    .ptr_next(ptr_adv)
  );

  // link inputs are synchronous; edges found against last sample
  assign start_seen = link.scl && cur_ff.scl_q && cur_ff.sda_q && !link.sda;
  assign stop_seen = link.scl && cur_ff.scl_q && !cur_ff.sda_q && link.sda;
  assign scl_rise = link.scl && !cur_ff.scl_q;
  assign scl_fall = !link.scl && cur_ff.scl_q;

  // read mux, pointer is never a source of data
  always_comb begin
    case (cur_ff.ptr)
      REG_CONFIG_A: rd_byte = cur_ff.cfg_a;
      REG_CONFIG_B: rd_byte = cur_ff.cfg_b;
      REG_OP_MODE: rd_byte = cur_ff.mode;
      REG_X_HIGH: rd_byte = sample_data[47:40];
      REG_X_LOW: rd_byte = sample_data[39:32];
      REG_Y_HIGH: rd_byte = sample_data[31:24];
      REG_Y_LOW: rd_byte = sample_data[23:16];
      REG_Z_HIGH: rd_byte = sample_data[15:8];
      REG_Z_LOW: rd_byte = sample_data[7:0];
      REG_STATE_FLAGS: rd_byte = state_flags;
      REG_IDENT_FIRST: rd_byte = IDENT_FIRST;
      REG_IDENT_SECOND: rd_byte = IDENT_SECOND;
      REG_IDENT_THIRD: rd_byte = IDENT_THIRD;
      default: rd_byte = BYTE_ZERO;
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.scl_q = link.scl;
    nxt_cur.sda_q = link.sda;
    if (start_seen) begin
      // any start, repeated or not, restarts address decode
      nxt_cur.st = D_ADDR;
      nxt_cur.bit_cnt = BIT_PRE;
      nxt_cur.ack_drive = 1'b0;
      nxt_cur.tx_on = 1'b0;
      nxt_cur.sda_low = 1'b0;
    end else if (stop_seen) begin
      nxt_cur.st = D_IDLE;
      nxt_cur.ack_drive = 1'b0;
      nxt_cur.tx_on = 1'b0;
      nxt_cur.sda_low = 1'b0;
    end else if (cur_ff.st != D_IDLE && cur_ff.st != D_IGNORE) begin
      // sample on rising edge, serial bits msb first
      if (scl_rise) begin
        // while sending, the shifter holds outgoing bits only
        if (cur_ff.bit_cnt <= BIT_LAST && !cur_ff.tx_on) begin
          nxt_cur.shift = {cur_ff.shift[6:0], link.sda};
        end else if (cur_ff.st == D_RDATA) begin
          nxt_cur.master_nack = link.sda;
        end
      end
      // outputs change only after falling edge, clock low
      if (scl_fall) begin
        nxt_cur.ack_drive = 1'b0;
        nxt_cur.sda_low = 1'b0;
        if (cur_ff.bit_cnt == BIT_LAST) begin
          nxt_cur.bit_cnt = BIT_ACK;
          case (cur_ff.st)
            D_ADDR: begin
              if (cur_ff.shift[7:1] == SLAVE_ADDR_FIELD) begin
                nxt_cur.ack_drive = 1'b1;
                nxt_cur.sda_low = 1'b1;
              end else begin
                nxt_cur.st = D_IGNORE;
              end
            end
            D_PTR: begin
              nxt_cur.ptr = cur_ff.shift;
              nxt_cur.ack_drive = 1'b1;
              nxt_cur.sda_low = 1'b1;
            end
            D_WDATA: begin
              // only defined bits of writable registers change
              case (cur_ff.ptr)
                REG_CONFIG_A: nxt_cur.cfg_a = cur_ff.shift & CONFIG_A_MASK;
                REG_CONFIG_B: nxt_cur.cfg_b = cur_ff.shift & CONFIG_B_MASK;
                REG_OP_MODE: nxt_cur.mode = cur_ff.shift & OP_MODE_MASK;
                default: nxt_cur.mode = cur_ff.mode;
              endcase
              nxt_cur.ptr = ptr_adv;
              nxt_cur.ack_drive = 1'b1;
              nxt_cur.sda_low = 1'b1;
            end
            D_RDATA: begin
              nxt_cur.ptr = ptr_adv;
              nxt_cur.tx_on = 1'b0; // release for master ack
            end
            default: nxt_cur.st = cur_ff.st;
          endcase
        end else if (cur_ff.bit_cnt == BIT_ACK) begin
          nxt_cur.bit_cnt = BIT_ZERO;
          if (cur_ff.st == D_ADDR) begin
            // direction bit picks read or write path
            nxt_cur.st = cur_ff.shift[0] ? D_RDATA : D_PTR;
          end else if (cur_ff.st == D_PTR) begin
            nxt_cur.st = D_WDATA;
          end
          if ((cur_ff.st == D_ADDR && cur_ff.shift[0]) ||
              (cur_ff.st == D_RDATA && !cur_ff.master_nack)) begin
            nxt_cur.shift = rd_byte;
            nxt_cur.tx_on = 1'b1;
            nxt_cur.sda_low = !rd_byte[7];
          end else if (cur_ff.st == D_RDATA) begin
            nxt_cur.st = D_IGNORE; // master refused, wait for stop
          end
        end else begin
          nxt_cur.bit_cnt = cur_ff.bit_cnt + BIT_ONE;
          if (cur_ff.tx_on) begin
            nxt_cur.sda_low = !cur_ff.shift[6];
            nxt_cur.shift = {cur_ff.shift[6:0], 1'b0};
          end
        end
      end
    end
    // nothing beyond these restores calibration; reset is power-up
  end

  // state register; reset is the power-up restore
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur_ff <= '{st: D_IDLE, scl_q: 1'b1, sda_q: 1'b1, bit_cnt: BIT_ZERO,
        shift: BYTE_ZERO, ptr: PTR_ZERO, ack_drive: 1'b0, tx_on: 1'b0,
        sda_low: 1'b0, master_nack: 1'b0, cfg_a: CONFIG_A_RESET,
        cfg_b: CONFIG_B_RESET, mode: OP_MODE_RESET};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ==========================================================
  // pins: enable low means this end pulls the line low
  assign link.sda_d_out = 1'b0;
  assign link.sda_d_oe_n = !cur_ff.sda_low;
  // stretch only while clock already low, between bits
  assign link.scl_d_oe_n = !(stall_req && !cur_ff.scl_q &&
    cur_ff.st != D_IDLE && cur_ff.st != D_IGNORE);
  assign config_a = cur_ff.cfg_a;
  assign config_b = cur_ff.cfg_b;
  assign op_mode = cur_ff.mode;
  assign busy = cur_ff.st != D_IDLE;
endmodule
`default_nettype wire

// file: logic/mgi_host.sv
// module: master end, drives clock and data under command registers
`timescale 1ns/1ps
`default_nettype none
module mgi_host
  import mgi_pkg::*;
#(
  parameter logic [9:0] HALF_PERIOD = HALF_STD_CNT
)
(
  input wire logic clk_sys,
  input wire logic rst,
  mgi_link_if.master link,
  input wire logic [1:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  output logic [7:0] cmd_rdata
);
  import mgi_pkg::*;

  if (HALF_PERIOD < HALF_FAST_CNT) begin : g_half_chk
    $error("half period too short");
  end

  // command register offsets on the local port
  localparam logic [1:0] OFS_CMD = 2'h0;
  localparam logic [1:0] OFS_DATA = 2'h1;
  localparam logic [1:0] OFS_STATUS = 2'h2;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_START = 3'b001, H_BIT = 3'b011,
    H_STOP = 3'b010, H_DONE = 3'b110
  } mgi_hstate_type;

  typedef struct packed {
    mgi_hstate_type st;
    logic [9:0] cnt;
    logic [1:0] phase;
    logic [3:0] bit_cnt;
    logic [8:0] shift;
    logic [7:0] rx;
    logic ack_in;
    logic scl_low;
    logic sda_low;
    logic [7:0] rdata;
  } mgi_host_type;

  mgi_host_type cur_ff;
  mgi_host_type nxt_cur;
  logic tick;

  assign tick = cur_ff.cnt == CNT_ZERO;

  // byte frame: 8 data bits then ack slot, msb first
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.rdata = BYTE_ZERO;
    if (cmd_rd) begin
      case (cmd_addr)
        OFS_DATA: nxt_cur.rdata = cur_ff.rx;
        OFS_STATUS: nxt_cur.rdata = {6'h00, cur_ff.ack_in,
          cur_ff.st != H_IDLE};
        default: nxt_cur.rdata = BYTE_ZERO;
      endcase
    end
    if (!tick) begin
      nxt_cur.cnt = cur_ff.cnt - CNT_ONE;
    end
    case (cur_ff.st)
      H_IDLE: begin
        if (cmd_wr && cmd_addr == OFS_DATA) begin
          nxt_cur.shift = {cmd_wdata, 1'b1};
        end else if (cmd_wr && cmd_addr == OFS_CMD) begin
          nxt_cur.cnt = HALF_PERIOD;
          nxt_cur.phase = 2'h0;
          nxt_cur.bit_cnt = BIT_ZERO;
          case (cmd_wdata[1:0])
            CMD_START: nxt_cur.st = H_START;
            CMD_STOP: nxt_cur.st = H_STOP;
            CMD_READ: begin
              // release data; ack slot carries our ack unless last
              nxt_cur.shift = {8'hFF, cmd_wdata[2]};
              nxt_cur.st = H_BIT;
            end
            default: nxt_cur.st = H_BIT;
          endcase
        end
      end
      H_START: if (tick) begin
        // sda falls while scl high, then scl low
        nxt_cur.cnt = HALF_PERIOD;
        nxt_cur.phase = cur_ff.phase + 2'h1;
        case (cur_ff.phase)
          2'h0: begin
            nxt_cur.sda_low = 1'b0;
            nxt_cur.scl_low = 1'b0;
          end
          2'h1: nxt_cur.sda_low = 1'b1;
          default: begin
            nxt_cur.scl_low = 1'b1;
            nxt_cur.st = H_DONE;
          end
        endcase
      end
      H_BIT: if (tick) begin
        nxt_cur.cnt = HALF_PERIOD;
        if (!cur_ff.scl_low) begin
          if (link.scl) begin
            // sample and drop clock; held low by slave means wait
            if (cur_ff.bit_cnt == BIT_ACK) begin
              nxt_cur.ack_in = !link.sda;
              nxt_cur.st = H_DONE;
            end else begin
              nxt_cur.rx = {cur_ff.rx[6:0], link.sda};
            end
            nxt_cur.bit_cnt = cur_ff.bit_cnt + BIT_ONE;
            nxt_cur.scl_low = 1'b1;
          end
        end else begin
          // data set and clock released on the same tick
          nxt_cur.sda_low = !cur_ff.shift[8];
          nxt_cur.shift = {cur_ff.shift[7:0], 1'b1};
          nxt_cur.scl_low = 1'b0;
        end
      end
      H_STOP: if (tick) begin
        nxt_cur.cnt = HALF_PERIOD;
        nxt_cur.phase = cur_ff.phase + 2'h1;
        case (cur_ff.phase)
          2'h0: nxt_cur.sda_low = 1'b1;
          2'h1: nxt_cur.scl_low = 1'b0;
          default: begin
            nxt_cur.sda_low = 1'b0;
            nxt_cur.st = H_DONE;
          end
        endcase
      end
      H_DONE: nxt_cur.st = H_IDLE;
      default: nxt_cur.st = H_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur_ff <= '{st: H_IDLE, cnt: CNT_ZERO, phase: 2'h0, bit_cnt: BIT_ZERO,
        shift: 9'h1FF, rx: BYTE_ZERO, ack_in: 1'b0, scl_low: 1'b0,
        sda_low: 1'b0, rdata: BYTE_ZERO};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign link.scl_out = 1'b0;
  assign link.scl_oe_n = !cur_ff.scl_low;
  assign link.sda_m_out = 1'b0;
  assign link.sda_m_oe_n = !cur_ff.sda_low;
  assign cmd_rdata = cur_ff.rdata;
endmodule
`default_nettype wire

// file: bench/mgi_link_checker.sv
// checker: timing and ownership assertions on the two-wire link
`timescale 1ns/1ps
`default_nettype none
module mgi_link_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_m_out,
  input wire logic sda_m_oe_n,
  input wire logic sda_d_out,
  input wire logic sda_d_oe_n,
  input wire logic scl_d_oe_n,
  input wire logic scl,
  input wire logic sda
);
  // ==========================================================
  // all assertions share the system clock and its reset
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // open drain: a driver may only ever pull low
  a_open_drain_low: assert property
    (!scl_out && !sda_m_out && !sda_d_out)
    else $error("link driver output data not low");
  a_scl_low_min: assert property
    ($fell(scl_oe_n) |-> (!scl_oe_n)[*8])
    else $error("master clock low phase too short");
  a_scl_high_min: assert property
    ($rose(scl_oe_n) |-> scl_oe_n[*8])
    else $error("master clock high phase too short");
  // device data moves only in the low clock phase
  a_dev_sda_low: assert property
    ($changed(sda_d_oe_n) |-> !scl && !$past(scl))
    else $error("device data changed near a high clock");
  a_bus_sda_stable: assert property
    ($rose(scl) |-> ##1 $stable(sda)[*3])
    else $error("data moved right after clock rise");
  // both pulling low agrees on open drain, but never while clock high
  a_no_contention: assert property
    (!sda_d_oe_n && !sda_m_oe_n |-> !scl)
    else $error("both ends pull data low with clock high");
  a_ack_master_free: assert property
    (!sda_d_oe_n && scl |-> sda_m_oe_n)
    else $error("master drives while device answers");
  a_start_dev_quiet: assert property
    ($fell(sda) && scl && $past(scl) |-> sda_d_oe_n[*2])
    else $error("device drives data at a start");
  a_stop_bus_free: assert property
    ($rose(sda) && scl && $past(scl) |-> scl_oe_n[*8])
    else $error("clock restarted right after stop");
  a_stretch_low_only: assert property
    ($fell(scl_d_oe_n) |-> !$past(scl))
    else $error("device pulled a high clock low");
  c_start: cover property ($fell(sda) && scl && $past(scl));
  c_stop: cover property ($rose(sda) && scl && $past(scl));
  c_ack: cover property ($rose(scl) && !sda_d_oe_n);
  c_stretch: cover property (!scl_d_oe_n);
endmodule
`default_nettype wire

// file: bench/testbench.sv
// testbench: both link ends joined, driven through the host command port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mgi_pkg::*;
  localparam int TIMEOUT = 100000;
  localparam logic [7:0] ID_SECOND = 8'hB2; // arbitrary identity value
  localparam logic [7:0] ID_THIRD = 8'hC3; // arbitrary identity value
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [1:0] cmd_addr = 2'h0;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_wr = 1'b0;
  logic cmd_rd = 1'b0;
  logic [7:0] cmd_rdata;
  logic [47:0] sample_data = 48'h1122_3344_55F6;
  logic [7:0] state_flags = 8'h01;
  logic stall_req = 1'b0;
  logic [7:0] cfg_a;
  logic [7:0] cfg_b;
  logic [7:0] op_mode;
  logic dev_busy;
  logic [7:0] d;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  // ==========================================================
  // the two ends face each other across one link
  mgi_link_if lnk();
  mgi_host #(.HALF_PERIOD(HALF_FAST_CNT)) u_mgi_host (.clk_sys(clk_sys),
    .rst(rst), .link(lnk.master), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_rdata(cmd_rdata));
  mgi_dev u_mgi_dev (.clk_sys(clk_sys), .rst(rst), .link(lnk.device),
    .sample_data(sample_data), .state_flags(state_flags),
    .stall_req(stall_req), .config_a(cfg_a), .config_b(cfg_b),
    .op_mode(op_mode), .busy(dev_busy));
  mgi_link_checker u_mgi_link_checker (.clk_sys(clk_sys), .rst(rst),
    .scl_out(lnk.scl_out), .scl_oe_n(lnk.scl_oe_n),
    .sda_m_out(lnk.sda_m_out), .sda_m_oe_n(lnk.sda_m_oe_n),
    .sda_d_out(lnk.sda_d_out), .sda_d_oe_n(lnk.sda_d_oe_n),
    .scl_d_oe_n(lnk.scl_d_oe_n), .scl(lnk.scl), .sda(lnk.sda));
  // ==========================================================
  // clock and hang guard
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == TIMEOUT) begin
      err_count++;
      final_report();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic bus_wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    cmd_addr <= a;
    cmd_wdata <= v;
    cmd_wr <= 1'b1;
    @(posedge clk_sys);
    cmd_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    cmd_addr <= a;
    cmd_rd <= 1'b1;
    @(posedge clk_sys);
    cmd_rd <= 1'b0;
    #1;
    v = cmd_rdata;
  endtask
  task automatic wait_idle;
    logic [7:0] st;
    st = 8'h01;
    for (int i = 0; i < 4000 && st[0] !== 1'b0; i++) begin
      bus_rd(2'h2, st);
    end
    check("host idle", {7'h00, st[0]}, 8'h00);
  endtask
  task automatic cond(input logic [1:0] code);
    bus_wr(2'h0, {6'h00, code});
    wait_idle();
  endtask
  // stall holds the device clock pull for 301 cycles before the byte's first bit, checking scl still low after 300
  task automatic wr_byte(input logic [7:0] b, input logic ack,
      input logic stall);
    logic [7:0] st;
    int i;
    bus_wr(2'h1, b);
    bus_wr(2'h0, {6'h00, CMD_WRITE});
    if (stall) begin
      i = 0;
      while (lnk.scl !== 1'b0 && i < 1000) begin
        @(posedge clk_sys);
        i++;
      end
      stall_req <= 1'b1;
      repeat (300) @(posedge clk_sys);
      #1;
      check("scl stalled", {7'h00, lnk.scl}, 8'h00);
      @(posedge clk_sys);
      stall_req <= 1'b0;
    end
    wait_idle();
    bus_rd(2'h2, st);
    check("ack", {7'h00, st[1]}, {7'h00, ack});
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] v);
    bus_wr(2'h0, {5'h00, last, CMD_READ});
    wait_idle();
    bus_rd(2'h1, v);
  endtask
  // opens a read at ptr: write address, pointer, repeated start
  task automatic rd_open(input logic [7:0] ptr);
    cond(CMD_START);
    wr_byte(ADDR_WR_BYTE, 1'b1, 1'b0);
    wr_byte(ptr, 1'b1, 1'b0);
    cond(CMD_START);
    wr_byte(ADDR_RD_BYTE, 1'b1, 1'b0);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    check("config a", cfg_a, CONFIG_A_RESET);
    check("config b", cfg_b, CONFIG_B_RESET);
    check("mode", op_mode, OP_MODE_RESET);
    check("idle lines", {6'h00, lnk.scl, lnk.sda}, 8'h03);
    check("dev busy", {7'h00, dev_busy}, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_write_cfg;
    cond(CMD_START);
    wr_byte(ADDR_WR_BYTE, 1'b1, 1'b0);
    wr_byte(REG_CONFIG_A, 1'b1, 1'b0);
    wr_byte(8'hFF, 1'b1, 1'b0);
    wr_byte(8'hFF, 1'b1, 1'b1);
    wr_byte(8'hFE, 1'b1, 1'b0);
    cond(CMD_STOP);
    check("config a", cfg_a, 8'hFF & CONFIG_A_MASK);
    check("config b", cfg_b, 8'hFF & CONFIG_B_MASK);
    check("mode", op_mode, 8'hFE & OP_MODE_MASK);
    $display("test write done");
  endtask
  task automatic t_read_wrap;
    rd_open(REG_Z_LOW);
    rd_byte(1'b0, d);
    check("z low", d, sample_data[7:0]);
    rd_byte(1'b0, d);
    check("flags", d, state_flags);
    rd_byte(1'b1, d);
    check("x high", d, sample_data[47:40]);
    cond(CMD_STOP);
    $display("test read wrap done");
  endtask
  task automatic t_ident_wrap;
    rd_open(REG_IDENT_SECOND);
    rd_byte(1'b0, d);
    check("ident b", d, ID_SECOND);
    rd_byte(1'b0, d);
    check("ident c", d, ID_THIRD);
    rd_byte(1'b1, d);
    check("config a", d, 8'hFF & CONFIG_A_MASK);
    cond(CMD_STOP);
    $display("test ident wrap done");
  endtask
  task automatic t_undefined;
    cond(CMD_START);
    wr_byte(ADDR_WR_BYTE, 1'b1, 1'b0);
    wr_byte(8'h20, 1'b1, 1'b0);
    wr_byte(8'h55, 1'b1, 1'b0);
    cond(CMD_STOP);
    check("config a", cfg_a, 8'hFF & CONFIG_A_MASK);
    check("config b", cfg_b, 8'hFF & CONFIG_B_MASK);
    rd_open(8'h20);
    rd_byte(1'b1, d);
    check("undefined", d, BYTE_ZERO);
    cond(CMD_STOP);
    $display("test undefined done");
  endtask
  task automatic t_wrong_addr;
    cond(CMD_START);
    wr_byte({SLAVE_ADDR_FIELD + 7'h01, 1'b0}, 1'b0, 1'b0);
    wr_byte(REG_CONFIG_A, 1'b0, 1'b0);
    cond(CMD_STOP);
    cond(CMD_START);
    wr_byte(ADDR_WR_BYTE, 1'b1, 1'b0);
    cond(CMD_STOP);
    check("dev busy", {7'h00, dev_busy}, 8'h00);
    $display("test wrong address done");
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    t_reset();
    t_write_cfg();
    t_read_wrap();
    t_ident_wrap();
    t_undefined();
    t_wrong_addr();
    final_report();
  end
endmodule
`default_nettype wire
